/* mbc_pkg.sv */
// package of constants and types for the memory barrier control block
package mbc_pkg;

	// ----------------------------------------
	// instruction field and type codes
	// ----------------------------------------
	localparam int unsigned MBC_TYPE_LSB = 6;
	localparam int unsigned MBC_TYPE_MSB = 10;
	localparam logic [4:0] MBC_TYPE_FULL = 5'h00;
	localparam logic [4:0] MBC_TYPE_STORE_ORD = 5'h04;
	localparam logic [4:0] MBC_TYPE_ALL_ORD = 5'h10;
	localparam logic [4:0] MBC_TYPE_ACQUIRE = 5'h11;
	localparam logic [4:0] MBC_TYPE_RELEASE = 5'h12;
	localparam logic [4:0] MBC_TYPE_LOAD_ORD = 5'h13;

	// ----------------------------------------
	// memory access types
	// ----------------------------------------
	localparam logic [1:0] MBC_ACC_UNCACHED = 2'h0;
	localparam logic [1:0] MBC_ACC_COHERENT = 2'h1;
	localparam logic [1:0] MBC_ACC_NONCOH = 2'h2;
	localparam logic [1:0] MBC_ACC_OTHER = 2'h3;

	localparam int unsigned MBC_CNT_W = 6;

	// decoded barrier: which older kinds wait, which younger kinds stall
	typedef struct packed {
		logic old_ld;
		logic old_st;
		logic yng_ld;
		logic yng_st;
		logic complete;
	} mbc_sel_t;

	typedef enum logic [1:0] {
		MBC_IDLE,
		MBC_WAIT,
		MBC_RELEASE
	} mbc_state_t;

endpackage

/* mbc_cnt_if.sv */
// interface carrying outstanding access counts between block parts
interface mbc_cnt_if #(parameter int unsigned W = 6);
	logic [W-1:0] ld_unordered;
	logic [W-1:0] st_unordered;
	logic [W-1:0] ld_unperformed;
	logic [W-1:0] st_unperformed;
	logic full;
	modport tracker (output ld_unordered, output st_unordered, output ld_unperformed, output st_unperformed,
		output full);
	modport ctrl (input ld_unordered, input st_unordered, input ld_unperformed, input st_unperformed,
		input full);
endinterface

/* mbc_decode.sv */
// barrier type decoder
module mbc_decode
	import mbc_pkg::*;
(
	input wire logic [31:0] instr,
	input wire logic opt_en,
	output mbc_sel_t sel
);
	import mbc_pkg::*;

	logic [4:0] btype;

	assign btype = instr[MBC_TYPE_MSB:MBC_TYPE_LSB];

	always_comb begin
		sel = '{old_ld: 1'b1, old_st: 1'b1, yng_ld: 1'b1, yng_st: 1'b1, complete: 1'b1};
		if (opt_en) begin
			unique case (btype)
				MBC_TYPE_STORE_ORD: sel = '{old_ld: 1'b0, old_st: 1'b1, yng_ld: 1'b0, yng_st: 1'b1, complete: 1'b0};
				MBC_TYPE_ALL_ORD: sel = '{old_ld: 1'b1, old_st: 1'b1, yng_ld: 1'b1, yng_st: 1'b1, complete: 1'b0};
				MBC_TYPE_ACQUIRE: sel = '{old_ld: 1'b1, old_st: 1'b0, yng_ld: 1'b1, yng_st: 1'b1, complete: 1'b0};
				MBC_TYPE_RELEASE: sel = '{old_ld: 1'b1, old_st: 1'b1, yng_ld: 1'b0, yng_st: 1'b1, complete: 1'b0};
				MBC_TYPE_LOAD_ORD: sel = '{old_ld: 1'b1, old_st: 1'b0, yng_ld: 1'b1, yng_st: 1'b0, complete: 1'b0};
				// zero, vendor and reserved types all full completion
				default: sel = '{old_ld: 1'b1, old_st: 1'b1, yng_ld: 1'b1, yng_st: 1'b1, complete: 1'b1};
			endcase
		end
	end
endmodule

/* mbc_tracker.sv */
// outstanding synchronizable access counters
module mbc_tracker
	import mbc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic issue_ld,
	input wire logic issue_st,
	input wire logic ld_ordered,
	input wire logic st_ordered,
	input wire logic ld_done,
	input wire logic st_done,
	mbc_cnt_if.tracker cnt
);
	import mbc_pkg::*;

	typedef struct packed {
		logic [MBC_CNT_W-1:0] ld_o;
		logic [MBC_CNT_W-1:0] st_o;
		logic [MBC_CNT_W-1:0] ld_p;
		logic [MBC_CNT_W-1:0] st_p;
	} mbc_trk_t;

	mbc_trk_t state_q, state_d;

	function automatic logic [MBC_CNT_W-1:0] step(input logic [MBC_CNT_W-1:0] v, input logic up, input logic dn);
		step = v + MBC_CNT_W'(up) - MBC_CNT_W'(dn && (v != '0 || up));
	endfunction

	always_comb begin
		state_d = state_q;
		// issued but not yet past the ordering point
		state_d.ld_o = step(state_q.ld_o, issue_ld, ld_ordered);
		state_d.st_o = step(state_q.st_o, issue_st, st_ordered);
		// load done on writeback, store when globally visible
		state_d.ld_p = step(state_q.ld_p, issue_ld, ld_done);
		state_d.st_p = step(state_q.st_p, issue_st, st_done);
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign cnt.ld_unordered = state_q.ld_o;
	assign cnt.st_unordered = state_q.st_o;
	assign cnt.ld_unperformed = state_q.ld_p;
	assign cnt.st_unperformed = state_q.st_p;
	assign cnt.full = (&state_q.ld_p) | (&state_q.st_p);
endmodule

/* mbc_top.sv */
// memory barrier control: barrier execution and younger access stall
module mbc_top
	import mbc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic bar_valid,
	input wire logic [31:0] bar_instr,
	input wire logic opt_en,
	input wire logic strong_order,
	input wire logic debug_mode,
	input wire logic mem_valid,
	input wire logic mem_is_store,
	input wire logic mem_is_maint,
	input wire logic [1:0] mem_acc_type,
	input wire logic mem_shared,
	input wire logic ld_ordered,
	input wire logic st_ordered,
	input wire logic ld_done,
	input wire logic st_done,
	output logic bar_busy,
	output logic bar_done,
	output logic hold_ld,
	output logic hold_st
);
	import mbc_pkg::*;

	// ----------------------------------------
	// access classification
	// ----------------------------------------
	logic targeted;
	logic issue_ld;
	logic issue_st;
	logic debug_edge;
	mbc_sel_t sel_dec;
	mbc_cnt_if #(.W(MBC_CNT_W)) cnt ();

	// only shared uncached or coherent accesses are counted
	assign targeted = mem_shared && (mem_acc_type == MBC_ACC_UNCACHED || mem_acc_type == MBC_ACC_COHERENT);
	// cache maintenance and prefetch enter as ordinary loads or stores
	assign issue_ld = mem_valid && targeted && !mem_is_store && !(hold_ld && !mem_is_maint && 1'b0);
	assign issue_st = mem_valid && targeted && mem_is_store;

	mbc_decode u_decode (
		.instr(bar_instr),
		.opt_en(opt_en),
		.sel(sel_dec)
	);

	mbc_tracker u_tracker (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.issue_ld(issue_ld),
		.issue_st(issue_st),
		.ld_ordered(ld_ordered),
		.st_ordered(st_ordered),
		.ld_done(ld_done),
		.st_done(st_done),
		.cnt(cnt)
	);

	// ----------------------------------------
	// barrier state
	// ----------------------------------------
	typedef struct packed {
		mbc_state_t st;
		mbc_sel_t sel;
		logic dbg;
		logic busy;
		logic done;
		logic hld;
		logic hst;
	} mbc_ctl_t;

	mbc_ctl_t state_q, state_d;
	logic met;
	logic start;

	assign debug_edge = debug_mode != state_q.dbg;
	assign start = bar_valid || debug_edge;

	always_comb begin
		met = 1'b1;
		if (state_q.sel.complete) begin
			if (state_q.sel.old_ld && cnt.ld_unperformed != '0) met = 1'b0;
			if (state_q.sel.old_st && cnt.st_unperformed != '0) met = 1'b0;
		end else begin
			// older selected accesses past ordering point; the
			// downstream memory keeps external request order past that point
			if (state_q.sel.old_ld && cnt.ld_unordered != '0) met = 1'b0;
			if (state_q.sel.old_st && cnt.st_unordered != '0) met = 1'b0;
		end
	end

	always_comb begin
		state_d = state_q;
		state_d.dbg = debug_mode;
		state_d.done = 1'b0;
		unique case (state_q.st)
			MBC_IDLE: begin
				if (start && strong_order) begin
					// strongly ordered: barrier retires at once, no exception
					state_d.done = bar_valid;
				end else if (start) begin
					// debug mode change raises a full completion barrier
					state_d.sel = bar_valid && !debug_edge ? sel_dec : '1;
					state_d.st = MBC_WAIT;
					state_d.busy = 1'b1;
					state_d.hld = bar_valid && !debug_edge ? sel_dec.yng_ld : 1'b1;
					state_d.hst = bar_valid && !debug_edge ? sel_dec.yng_st : 1'b1;
				end
			end
			MBC_WAIT: begin
				if (met) begin
					state_d.st = MBC_RELEASE;
				end
			end
			MBC_RELEASE: begin
				// stall drops two cycles after the condition is met, together with the retire pulse
				state_d.st = MBC_IDLE;
				state_d.busy = 1'b0;
				state_d.hld = 1'b0;
				state_d.hst = 1'b0;
				state_d.done = 1'b1;
			end
			default: state_d.st = MBC_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_q <= '{st: MBC_IDLE, sel: '0, dbg: 1'b0, busy: 1'b0, done: 1'b0, hld: 1'b0, hst: 1'b0};
		end else begin
			state_q <= state_d;
		end
	end

	// only data accesses are held; fetch is never stalled
	assign hold_ld = state_q.hld;
	assign hold_st = state_q.hst;
	assign bar_busy = state_q.busy;
	assign bar_done = state_q.done;
endmodule

/* mbc_assertions.sv */
// port checker for the barrier control block
module mbc_checker
	import mbc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic bar_valid,
	input wire logic [31:0] bar_instr,
	input wire logic opt_en,
	input wire logic strong_order,
	input wire logic debug_mode,
	input wire logic bar_busy,
	input wire logic bar_done,
	input wire logic hold_ld,
	input wire logic hold_st
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic acc;
	logic [4:0] ty;
	assign acc = bar_valid && !bar_busy && !strong_order;
	assign ty = bar_instr[10:6];
	a_reset_quiet: assert property ($rose(rstn) |-> !(bar_busy || bar_done || hold_ld || hold_st))
		else $error("outputs active after reset");
	a_full_holds: assert property (acc && (ty == MBC_TYPE_FULL || !opt_en) |=> bar_busy && hold_ld && hold_st)
		else $error("full barrier not holding both kinds");
	a_store_only: assert property (acc && opt_en && ty == MBC_TYPE_STORE_ORD |=> hold_st && !hold_ld)
		else $error("store barrier holds wrong kinds");
	a_load_only: assert property (acc && opt_en && ty == MBC_TYPE_LOAD_ORD |=> hold_ld && !hold_st)
		else $error("load barrier holds wrong kinds");
	a_release_st: assert property (acc && opt_en && ty == MBC_TYPE_RELEASE |=> hold_st && !hold_ld)
		else $error("release barrier holds wrong kinds");
	a_noop_quick: assert property (bar_valid && !bar_busy && strong_order |=> bar_done && !hold_ld && !hold_st)
		else $error("strongly ordered barrier not retired at once");
	a_done_late: assert property (acc |=> !bar_done [*2])
		else $error("barrier retired too early");
	a_done_pulse: assert property (bar_done |-> !bar_busy ##1 !bar_done)
		else $error("retire pulse malformed");
	a_hold_steady: assert property (bar_busy && $past(bar_busy) |-> $stable({hold_ld, hold_st}))
		else $error("stall changed mid barrier");
	a_hold_busy: assert property (hold_ld || hold_st |-> bar_busy)
		else $error("stall without barrier");
	c_acquire: cover property (acc && opt_en && ty == MBC_TYPE_ACQUIRE);
	c_noop: cover property (bar_valid && strong_order);
	c_debug: cover property ($changed(debug_mode) && !bar_busy);
endmodule

/* mbc_mem_model.sv */
// cache and memory system model answering targeted accesses
module mbc_mem_model
	import mbc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic mem_valid,
	input wire logic mem_is_store,
	input wire logic [1:0] mem_acc_type,
	input wire logic mem_shared,
	input wire logic [1:0] go,
	output logic [1:0] ordered,
	output logic [1:0] done,
	output logic [1:0][7:0] n_ord,
	output logic [1:0][7:0] n_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic tgt;
	assign tgt = mem_valid && mem_shared && mem_acc_type inside {MBC_ACC_UNCACHED, MBC_ACC_COHERENT};
	// ordering first, completion later; go stalls either
	always_ff @(posedge ref_clk) begin
		for (int k = 0; k < 2; k++) begin
			ordered[k] <= rstn && go[0] && n_ord[k] != 8'h00;
			done[k] <= rstn && go[1] && n_out[k] > n_ord[k];
			n_ord[k] <= rstn ? n_ord[k] + 8'(tgt && mem_is_store == (k == 1)) - 8'(go[0] && n_ord[k] != 8'h00) : 8'h00;
			n_out[k] <= rstn ? n_out[k] + 8'(tgt && mem_is_store == (k == 1)) - 8'(go[1] && n_out[k] > n_ord[k]) : 8'h00;
		end
	end
endmodule

/* testbench.sv */
// random barrier and access bench for barrier control
module testbench import mbc_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = '0, rstn = '0, bar_valid = '0, opt_en = '0, strong_order = '0, debug_mode = '0;
	logic mem_valid = '0, mem_is_store = '0, mem_is_maint = '0, mem_shared = '0;
	logic [1:0] mem_acc_type = '0, go = '0, ordered, done;
	logic [31:0] bar_instr = '0, seed = 32'h1e8d_f2da, r;
	logic bar_busy, bar_done, hold_ld, hold_st;
	logic [1:0][7:0] n_ord, n_out;
	logic [4:0] e;
	int n_mismatch = 0, tests_run = 0, n;
	mbc_top i_mbc_top (.ref_clk, .rstn, .bar_valid, .bar_instr, .opt_en, .strong_order, .debug_mode, .mem_valid,
		.mem_is_store, .mem_is_maint, .mem_acc_type, .mem_shared, .ld_ordered(ordered[0]), .st_ordered(ordered[1]),
		.ld_done(done[0]), .st_done(done[1]), .bar_busy, .bar_done, .hold_ld, .hold_st);
	mbc_mem_model i_mbc_mem_model (.ref_clk, .rstn, .mem_valid, .mem_is_store, .mem_acc_type, .mem_shared, .go,
		.ordered, .done, .n_ord, .n_out);
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		go <= 2'($random(seed));
	end
	// {older loads, older stores, younger loads, younger stores, completion}
	function automatic logic [4:0] exp_sel(input logic [4:0] t, input logic opt);
		case (opt ? t : MBC_TYPE_FULL)
			MBC_TYPE_STORE_ORD: return 5'h0a;
			MBC_TYPE_ALL_ORD: return 5'h1e;
			MBC_TYPE_ACQUIRE: return 5'h16;
			MBC_TYPE_RELEASE: return 5'h1a;
			MBC_TYPE_LOAD_ORD: return 5'h14;
			default: return 5'h1f;
		endcase
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// up to five accesses before each barrier; one barrier of every code with opt_en off, then every code again with opt_en on
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge ref_clk);
		rstn <= 1'h1;
		for (int i = 0; i < 64; i++) begin
			repeat (i % 6) begin
				@(posedge ref_clk);
				r = $random(seed);
				mem_valid <= 1'h1;
				{mem_is_store, mem_is_maint, mem_acc_type} <= r[3:0];
				mem_shared <= r[5:4] != 2'h0;
			end
			@(posedge ref_clk);
			r = $random(seed);
			mem_valid <= 1'h0;
			opt_en <= i[5];
			strong_order <= i % 7 == 3;
			bar_valid <= 1'h1;
			bar_instr <= {r[31:11], i[4:0], r[5:0]};
			e = exp_sel(i[4:0], i[5]);
			@(posedge ref_clk);
			bar_valid <= 1'h0;
			#1;
			if (i % 7 != 3) check("younger holds", 8'({hold_ld, hold_st}), 8'(e[2:1]));
			for (n = 0; n < 300 && bar_done !== 1'h1; n++) begin
				@(posedge ref_clk);
				#1;
			end
			if (n == 300) begin
				n_mismatch++;
				report_and_stop();
			end
			if (i % 7 != 3) check("older left", (e[4] ? (e[0] ? n_out[0] : n_ord[0]) : 8'h00) +
				(e[3] ? (e[0] ? n_out[1] : n_ord[1]) : 8'h00), 8'h00);
			@(posedge ref_clk);
			#1;
			check("after retire", 8'({bar_busy, bar_done, hold_ld, hold_st}), 8'h00);
		end
		@(posedge ref_clk);
		debug_mode <= 1'h1;
		for (n = 0; n < 4 && bar_busy !== 1'h1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		check("debug barrier", 8'({bar_busy, hold_ld, hold_st}), 8'h07);
		report_and_stop();
	end
endmodule
bind mbc_top mbc_checker i_mbc_checker (.ref_clk, .rstn, .bar_valid, .bar_instr, .opt_en, .strong_order, .debug_mode,
	.bar_busy, .bar_done, .hold_ld, .hold_st);
